// *** logic/sims_second_interrupt_output_ctrl.sv ***
// Second interrupt output: event flags, masks and raw status readback.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Five mask words mirror the five flag words
// - Mask one blocks flag, zero lets through
// - Boot-complete mask resets clear, others set
// - Control bit zero masks output; resets clear
// - Six sticky edge flags, write one clears
// - Always-on masks in own register, reset set
// - Raw status three bit fifteen: live warning
module sims_second_interrupt_output_ctrl
    import sims_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    input  wire logic [79:0] main_event_flags_in,
    input  wire logic        jack_detect_in,
    input  wire logic        gpio_line_five_in,
    input  wire logic        mic_clamp_in,
    input  wire logic        dsp1_ram_ready_in,
    input  wire logic        dsp_second_interrupt_output_in,
    input  wire logic        dsp_irq1_in,
    input  wire logic        speaker_overtemp_warning_in,
    output logic             second_interrupt_output_out
);
    typedef struct packed {
        logic                   master_mask;
        logic [15:0]            aod_flags;
        logic [15:0]            aod_mask;
        logic [AOD_SOURCES-1:0] prev_lvl;
        logic                   prev_ok;
        logic [15:0]            rdata;
        logic                   rd_bank;
        logic                   irq;
    } sims_ctrl_s;

    sims_ctrl_s             st_r;
    sims_ctrl_s             st_nxt;
    logic [AOD_SOURCES-1:0] src_lvl;
    logic [15:0]            aod_set;
    logic [79:0]            bank_mask;
    logic [15:0]            bank_rdata;
    logic                   in_bank;
    logic                   bank_wr;
    logic [2:0]             bank_idx;
    logic                   pend_any;

    assign src_lvl  = {mic_clamp_in, gpio_line_five_in, jack_detect_in};
    assign in_bank  = (reg_addr_in >= ADDR_MASK_BASE) && (reg_addr_in <= ADDR_MASK_LAST);
    assign bank_wr  = reg_wr_in && in_bank;
    assign bank_idx = 3'(reg_addr_in - ADDR_MASK_BASE);

    // ==========================================================
    // Edge detectors, one rise and one fall per source
    // prev_ok stops the first level sampled after reset from looking like an edge
    genvar gi;
    generate
        for (gi = 0; gi < AOD_SOURCES; gi++) begin : g_edge
            assign aod_set[AOD_LSB+2*gi]   = st_r.prev_ok & src_lvl[gi] & ~st_r.prev_lvl[gi];
            assign aod_set[AOD_LSB+2*gi+1] = st_r.prev_ok & ~src_lvl[gi] & st_r.prev_lvl[gi];
        end
    endgenerate
    assign aod_set[1:0]  = 2'b00;
    assign aod_set[15:8] = 8'h00;

    // ==========================================================
    // Mask bank, one mask bit per main event flag
    sims_mask_mem u_mask_mem (
        .core_clk_in  (core_clk_in),
        .arst_n_in    (arst_n_in),
        .clk_en_in    (clk_en_in),
        .wr_en_in     (bank_wr),
        .wr_idx_in    (bank_idx),
        .wr_data_in   (reg_wdata_in),
        .rd_en_in     (reg_rd_in),
        .rd_idx_in    (bank_idx),
        .rd_data_out  (bank_rdata),
        .mask_vec_out (bank_mask)
    );

    // Any flag whose mask bit is clear, gated by the master mask
    assign pend_any = ~st_r.master_mask &
                      ((|(main_event_flags_in & ~bank_mask)) |
                       (|(st_r.aod_flags & ~st_r.aod_mask & AOD_FIELD)));

    // ==========================================================
    // Register writes, sticky flags and read mux
    always_comb begin
        st_nxt          = st_r;
        st_nxt.prev_lvl = src_lvl;
        st_nxt.prev_ok  = 1'b1;
        st_nxt.irq      = pend_any;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_CTRL:      st_nxt.master_mask = reg_wdata_in[CTRL_MASTER_BIT];
                ADDR_AOD_FLAGS: st_nxt.aod_flags   = st_r.aod_flags & ~reg_wdata_in;
                ADDR_AOD_MASK:  st_nxt.aod_mask    = reg_wdata_in & AOD_FIELD;
                default:        st_nxt.aod_flags   = st_r.aod_flags;
            endcase
        end
        // Set after clear so an edge in the clearing cycle is kept
        st_nxt.aod_flags = (st_nxt.aod_flags | aod_set) & AOD_FIELD;
        if (reg_rd_in) begin
            st_nxt.rd_bank = in_bank;
            st_nxt.rdata   = 16'h0000;
            unique case (reg_addr_in)
                ADDR_CTRL:      st_nxt.rdata[CTRL_MASTER_BIT] = st_r.master_mask;
                ADDR_RAW2: begin
                    st_nxt.rdata[RAW2_RAM_RDY_BIT] = dsp1_ram_ready_in;
                    st_nxt.rdata[RAW2_DSP2_BIT]    = dsp_second_interrupt_output_in;
                    st_nxt.rdata[RAW2_DSP1_BIT]    = dsp_irq1_in;
                end
                ADDR_RAW3:      st_nxt.rdata[RAW3_SPK_WARN_BIT] = speaker_overtemp_warning_in;
                ADDR_AOD_FLAGS: st_nxt.rdata = st_r.aod_flags;
                ADDR_AOD_MASK:  st_nxt.rdata = st_r.aod_mask;
                default:        st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= '{master_mask: CTRL_MASTER_RST, aod_flags: AOD_FLAGS_RST,
                      aod_mask: AOD_MASK_RST, prev_lvl: '0, prev_ok: 1'b0,
                      rdata: 16'h0000, rd_bank: 1'b0, irq: 1'b0};
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // Bank data already sits in a register inside the memory
    assign reg_rdata_out               = st_r.rd_bank ? bank_rdata : st_r.rdata;
    assign second_interrupt_output_out = st_r.irq;

    // ==========================================================
    // Checks
    // High only up to the first edge after reset, so reset values can be checked
    logic first_r;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Reset values of every mask
    bank_reset_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        first_r |-> (bank_mask == MASK_BANK_RST) && !bank_mask[BOOT_FLAT_BIT]
                    && (st_r.aod_mask == AOD_MASK_RST) && !st_r.master_mask)
        else $error("mask reset values wrong");

    // Output path: pending term, mask bits and master mask
    irq_follow_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        clk_en_in |=> second_interrupt_output_out == $past(pend_any))
        else $error("interrupt output does not follow pending state");

    master_block_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && st_r.master_mask) |=> !second_interrupt_output_out)
        else $error("master mask did not suppress output");

    all_masked_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && (&bank_mask) && ((st_r.aod_mask & AOD_FIELD) == AOD_FIELD))
        |=> !second_interrupt_output_out)
        else $error("masked flags reached the output");

    // Sticky always-on flags
    jack_rise_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && st_r.prev_ok && !st_r.prev_lvl[0] && jack_detect_in)
        |=> st_r.aod_flags[AOD_LSB])
        else $error("jack rise edge not captured");

    flag_clear_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_wr_in && reg_addr_in == ADDR_AOD_FLAGS && aod_set == 16'h0000)
        |=> ((st_r.aod_flags & $past(reg_wdata_in)) == 16'h0000))
        else $error("write one did not clear flag");

    flag_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !(reg_wr_in && reg_addr_in == ADDR_AOD_FLAGS))
        |=> ((st_r.aod_flags & $past(st_r.aod_flags)) == $past(st_r.aod_flags)))
        else $error("sticky flag lost without a clear");

    // Register writes and read data
    aod_mask_wr_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_wr_in && reg_addr_in == ADDR_AOD_MASK)
        |=> st_r.aod_mask == ($past(reg_wdata_in) & AOD_FIELD))
        else $error("always-on mask write lost");

    bank_write_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_wr_in && reg_addr_in == ADDR_MASK_BASE)
        |=> bank_mask[15:0] == $past(reg_wdata_in))
        else $error("mask bank word not written");

    warn_read_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_rd_in && reg_addr_in == ADDR_RAW3)
        |=> reg_rdata_out[RAW3_SPK_WARN_BIT] == $past(speaker_overtemp_warning_in))
        else $error("warning status not live");

    bank_read_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_rd_in && in_bank)
        |=> reg_rdata_out == $past(bank_mask[bank_idx*16 +: 16]))
        else $error("mask bank word read back wrong");

    flag_read_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_rd_in && reg_addr_in == ADDR_AOD_FLAGS)
        |=> reg_rdata_out == $past(st_r.aod_flags))
        else $error("always-on flags read back wrong");

    // An unmasked flag must raise the output while the master mask is clear
    main_pass_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !st_r.master_mask && (|(main_event_flags_in & ~bank_mask)))
        |=> second_interrupt_output_out)
        else $error("unmasked main flag did not reach output");

    aod_pass_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !st_r.master_mask && (|(st_r.aod_flags & ~st_r.aod_mask & AOD_FIELD)))
        |=> second_interrupt_output_out)
        else $error("unmasked always-on flag did not reach output");
endmodule
`default_nettype wire

// *** logic/sims_pkg.sv ***
// Constants for the second interrupt output mask logic.
package sims_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [15:0] ADDR_MASK_BASE = 16'h0D18;
    localparam logic [15:0] ADDR_MASK_LAST = 16'h0D1C;
    localparam logic [15:0] ADDR_CTRL      = 16'h0D1F;
    localparam logic [15:0] ADDR_RAW2      = 16'h0D20;
    localparam logic [15:0] ADDR_RAW3      = 16'h0D21;
    localparam logic [15:0] ADDR_AOD_FLAGS = 16'h0D52;
    localparam logic [15:0] ADDR_AOD_MASK  = 16'h0D54;

    // ==========================================================
    // Mask bank layout and reset values
    localparam int          MASK_WORDS     = 5;
    localparam int          BANK_BITS      = 80;
    localparam int          BOOT_FLAT_BIT  = 0;
    localparam logic [79:0] MASK_BANK_RST  = 80'hFFFF_FFFF_FFFF_FFFF_FFFE;

    // ==========================================================
    // Control register
    localparam int          CTRL_MASTER_BIT = 0;
    localparam logic        CTRL_MASTER_RST = 1'b0;

    // ==========================================================
    // Always-on event flags: bit 2+2i rise, 3+2i fall
    localparam int          AOD_SOURCES    = 3;
    localparam int          AOD_LSB        = 2;
    localparam logic [15:0] AOD_FIELD      = 16'h00FC;
    localparam logic [15:0] AOD_FLAGS_RST  = 16'h0000;
    localparam logic [15:0] AOD_MASK_RST   = 16'h00FC;

    // ==========================================================
    // Raw status bit positions
    localparam int          RAW2_RAM_RDY_BIT = 8;
    localparam int          RAW2_DSP2_BIT    = 1;
    localparam int          RAW2_DSP1_BIT    = 0;
    localparam int          RAW3_SPK_WARN_BIT = 15;
endpackage

// *** logic/sims_mask_mem.sv ***
// Five-word mask bank with registered read data.
`timescale 1ns/1ps
`default_nettype none
module sims_mask_mem
    import sims_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        wr_en_in,
    input  wire logic [2:0]  wr_idx_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic        rd_en_in,
    input  wire logic [2:0]  rd_idx_in,
    output logic      [15:0] rd_data_out,
    output logic      [79:0] mask_vec_out
);
    typedef struct packed {
        logic [MASK_WORDS-1:0][15:0] words;
        logic [15:0]                 rdata;
    } sims_mem_s;

    sims_mem_s st_r;
    sims_mem_s st_nxt;

    // ==========================================================
    // Next state: write then registered read
    always_comb begin
        st_nxt = st_r;
        if (wr_en_in && (wr_idx_in < 3'(MASK_WORDS))) begin
            st_nxt.words[wr_idx_in] = wr_data_in;
        end
        if (rd_en_in) begin
            st_nxt.rdata = (rd_idx_in < 3'(MASK_WORDS)) ? st_r.words[rd_idx_in] : 16'h0000;
        end
    end

    // Boot-complete mask starts clear, the rest masked
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= {MASK_BANK_RST, 16'h0000};
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out  = st_r.rdata;
    assign mask_vec_out = st_r.words;
endmodule
`default_nettype wire

// *** verif/sims_host_model.sv ***
// Host model that reaches the interrupt block registers.
`timescale 1ns/1ps
`default_nettype none
module sims_host_model (
    input  wire logic        core_clk_in,
    output logic      [15:0] reg_addr_out,
    output logic      [15:0] reg_wdata_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    input  wire logic [15:0] reg_rdata_in
);
    // ==========================================
    // Idle port
    initial begin
        reg_addr_out  = 16'h0000;
        reg_wdata_out = 16'h0000;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
    end
    // One-cycle strobe; released lines show inverted values so stale data never looks valid
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d; // Ones clear flags
        reg_wr_out    <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_out    <= 1'b0;
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
    endtask
    // Data is taken once the edge after the strobe has landed
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_rd_out   <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_out   <= 1'b0;
        reg_addr_out <= ~a;
        @(negedge core_clk_in);
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the second interrupt output mask logic.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sims_pkg::*;
    // ==========================================
    // Connections and reference state
    logic        core_clk_in = 1'b0;
    logic        arst_n_in   = 1'b0;
    logic        clk_en_in   = 1'b1;
    logic [15:0] addr, wdata, rdata;
    logic        wr, rd, irq;
    logic [79:0] evt        = '0;
    logic [2:0]  src        = '0;
    logic [3:0]  lvl        = '0;
    logic [15:0] m_mask [5];
    logic [15:0] m_ctrl     = 16'h0000;
    logic [15:0] m_aodm     = AOD_MASK_RST;
    logic [15:0] m_flags    = 16'h0000;
    logic [31:0] seed       = 32'h0000_0040;
    int          err_total  = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    sims_second_interrupt_output_ctrl i_sims_second_interrupt_output_ctrl (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .main_event_flags_in(evt), .jack_detect_in(src[0]), .gpio_line_five_in(src[1]), .mic_clamp_in(src[2]),
        .dsp1_ram_ready_in(lvl[3]), .dsp_second_interrupt_output_in(lvl[2]), .dsp_irq1_in(lvl[1]),
        .speaker_overtemp_warning_in(lvl[0]), .second_interrupt_output_out(irq));
    sims_host_model i_sims_host_model (.core_clk_in(core_clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));

    // ==========================================
    // Clock and hang guard, far above the few hundred cycles needed
    always #10 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    // ==========================================
    // Reference model
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] mdl(input logic [15:0] a);
        if (a >= ADDR_MASK_BASE && a <= ADDR_MASK_LAST) return m_mask[a[2:0]];
        case (a)
            ADDR_CTRL:      return m_ctrl;
            ADDR_RAW2:      return {7'h00, lvl[3], 6'h00, lvl[2], lvl[1]};
            ADDR_RAW3:      return {lvl[0], 15'h0000};
            ADDR_AOD_FLAGS: return m_flags;
            ADDR_AOD_MASK:  return m_aodm;
            default:        return 16'h0000;
        endcase
    endfunction
    function automatic logic exp_irq();
        logic [79:0] mk;
        mk = {m_mask[4], m_mask[3], m_mask[2], m_mask[1], m_mask[0]};
        return !m_ctrl[0] && (|(evt & ~mk) || |(m_flags & ~m_aodm & AOD_FIELD));
    endfunction

    // ==========================================
    // Compare, access and stimulus tasks
    task automatic chk_reg(input logic [15:0] a, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("Error reg %h expected %h seen %h", a, e, g);
        end
    endtask
    task automatic chk_irq();
        @(negedge core_clk_in);
        n_compared++;
        if (irq !== exp_irq()) begin
            err_total++;
            $display("Error irq expected %b seen %b", exp_irq(), irq);
        end
    endtask
    task automatic rdc(input logic [15:0] a);
        logic [15:0] d;
        i_sims_host_model.rd(a, d);
        chk_reg(a, mdl(a), d);
    endtask
    task automatic wrm(input logic [15:0] a, input logic [15:0] d);
        i_sims_host_model.wr(a, d);
        if (a >= ADDR_MASK_BASE && a <= ADDR_MASK_LAST) m_mask[a[2:0]] = d;
        if (a == ADDR_CTRL) m_ctrl = d & 16'h0001;
        if (a == ADDR_AOD_FLAGS) m_flags = m_flags & ~d;
        if (a == ADDR_AOD_MASK) m_aodm = d & AOD_FIELD;
    endtask
    // Source levels; rise sets bit 2+2i, fall bit 3+2i
    task automatic step_src(input logic [2:0] nv);
        for (int i = 0; i < AOD_SOURCES; i++) begin
            if (!src[i] && nv[i]) m_flags[AOD_LSB + 2 * i] = 1'b1;
            if (src[i] && !nv[i]) m_flags[AOD_LSB + 2 * i + 1] = 1'b1;
        end
        @(posedge core_clk_in);
        src <= nv;
        repeat (3) @(posedge core_clk_in);
    endtask
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        for (int i = 0; i < MASK_WORDS; i++) m_mask[i] = MASK_BANK_RST[16 * i +: 16];
        repeat (10) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        for (int i = 0; i < MASK_WORDS; i++) rdc(ADDR_MASK_BASE + 16'(i));
        rdc(ADDR_CTRL);
        rdc(ADDR_AOD_MASK);
        rdc(ADDR_AOD_FLAGS);
        @(posedge core_clk_in);
        evt <= 80'h1;
        repeat (3) @(posedge core_clk_in);
        chk_irq();
        // Random masks against one random flag, so about half get through
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < MASK_WORDS; i++) begin
                seed = xs(seed);
                wrm(ADDR_MASK_BASE + 16'(i), seed[15:0]);
                rdc(ADDR_MASK_BASE + 16'(i));
            end
            seed = xs(seed);
            @(posedge core_clk_in);
            evt <= 80'h1 << (seed % 80);
            repeat (3) @(posedge core_clk_in);
            chk_irq();
        end
        // Master mask over an unmasked flag
        @(posedge core_clk_in);
        evt <= 80'h1;
        wrm(ADDR_MASK_BASE, 16'h0000);
        for (int m = 0; m < 2; m++) begin
            wrm(ADDR_CTRL, m ? 16'h0000 : 16'hFFFF);
            rdc(ADDR_CTRL);
            chk_irq();
        end
        // Every bank and always-on mask set: all main flags present, none may reach the output
        for (int i = 0; i < MASK_WORDS; i++) wrm(ADDR_MASK_BASE + 16'(i), 16'hFFFF);
        wrm(ADDR_AOD_MASK, 16'hFFFF);
        @(posedge core_clk_in);
        evt <= '1;
        repeat (3) @(posedge core_clk_in);
        chk_irq();
        // Read-only, unmapped and frozen writes are ignored
        wrm(ADDR_RAW3, 16'hFFFF);
        rdc(ADDR_RAW3);
        wrm(16'h0D1E, 16'hFFFF);
        rdc(16'h0D1E);
        @(posedge core_clk_in);
        clk_en_in <= 1'b0;
        i_sims_host_model.wr(ADDR_MASK_BASE, 16'h1234);
        clk_en_in <= 1'b1;
        rdc(ADDR_MASK_BASE);
        // Always-on edges, masks and one-to-clear
        @(posedge core_clk_in);
        evt <= '0;
        for (int r = 0; r < 8; r++) begin
            seed = xs(seed);
            step_src(seed[2:0]);
            rdc(ADDR_AOD_FLAGS);
            wrm(ADDR_AOD_MASK, seed[15:0]);
            rdc(ADDR_AOD_MASK);
            chk_irq();
            wrm(ADDR_AOD_FLAGS, seed[31:16]);
            rdc(ADDR_AOD_FLAGS);
        end
        // Live raw status levels
        for (int r = 0; r < 6; r++) begin
            seed = xs(seed);
            @(posedge core_clk_in);
            lvl <= seed[3:0];
            rdc(ADDR_RAW2);
            rdc(ADDR_RAW3);
        end
        conclude();
    end
endmodule
`default_nettype wire
